//--- design/aprd_pkg.sv
package aprd_pkg;
   // Clock and timing figures
   localparam int unsigned CLK_HZ = 40_000_000;
   localparam int unsigned REQ_SETTLE_MS = 100;
   localparam int unsigned REQ_SETTLE_CYC = CLK_HZ / 1000 * REQ_SETTLE_MS;
   localparam int unsigned TAIL_GAP_MS = 25;
   localparam int unsigned TAIL_GAP_CYC = CLK_HZ / 1000 * TAIL_GAP_MS;
   localparam int unsigned BAUD_BPS = 9600;
   localparam int unsigned BIT_CYC = CLK_HZ / BAUD_BPS;
   localparam longint unsigned INIT_RPM = 1250;
   localparam longint unsigned INIT_CNT_PER_REV = 131072;
   localparam int unsigned PULSE_CYC =
      int'((longint'(CLK_HZ) * 60) / (INIT_RPM * INIT_CNT_PER_REV));
   // Single-turn resolutions
   localparam logic [22:0] TOP_17BIT = 23'h01ffff;
   localparam logic [22:0] TOP_23BIT = 23'h7fffff;
   localparam int unsigned RES_SHIFT = 6;
   // Register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_TURNS = 8'h08;
   localparam logic [7:0] OFS_POSITION = 8'h0c;
   // Control fields
   localparam int unsigned CTRL_ASSIGN_LSB = 0;
   localparam int unsigned CTRL_AXIS_B_BIT = 4;
   localparam int unsigned CTRL_CLR_TURNS_BIT = 8;
   localparam logic [3:0] ASSIGN_RST = 4'h0;
   localparam logic [3:0] ASSIGN_TERMINAL = 4'h4;
   // Encoder usage modes
   typedef enum logic [1:0] {
      APRD_MODE_ABS_SERIAL = 2'b00,
      APRD_MODE_INCR = 2'b01,
      APRD_MODE_ABS_QUIET = 2'b10
   } aprd_mode_t;
   // Transfer sequence
   typedef enum logic [2:0] {
      APRD_NORMAL = 3'b000,
      APRD_SETTLE = 3'b001,
      APRD_CONVERT = 3'b010,
      APRD_SEND = 3'b011,
      APRD_PULSES = 3'b100
   } aprd_state_t;
   // Captured AHB address phase
   typedef struct packed {
      logic valid;
      logic write;
      logic [7:0] addr;
   } aprd_aphase_t;
   // Serial frame characters
   localparam logic [6:0] CHAR_HEAD = 7'h50;
   localparam logic [6:0] CHAR_PLUS = 7'h2b;
   localparam logic [6:0] CHAR_MINUS = 7'h2d;
   localparam logic [6:0] CHAR_ZERO = 7'h30;
   localparam logic [6:0] CHAR_END = 7'h0d;
   localparam logic [2:0] LAST_BYTE = 3'h7;
   localparam logic [3:0] LAST_BIT = 4'h9;
   localparam logic [4:0] DABBLE_STEPS = 5'h10;
endpackage : aprd_pkg

//--- design/aprd_readout.sv
// Design decisions made here: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Revolution count is signed 16-bit and wraps +32767 to -32768 and back.
// - Single-turn position counts 131072 or 8388608 per revolution by fitted encoder.
// - Request low, also at power-on, means no absolute data wanted.
// - Request rising edge starts transfer: revolution data, then initial pulses.
// - Motor stays de-energized and panel shows off during the transfer.
// - Request unassigned by default; digit 4 takes terminal four, axis B eight.
// - Usage mode 0 absolute with serial, 1 incremental, 2 absolute silent.
// - Incremental mode ignores request; mode change needs a power cycle.
// - Phase A serial then pulses, phase B pulses, index pulse always.
// - Serial pending state begins 100 ms after request rises.
// - Absolute information goes out as eight serial bytes on phase A.
// - Normal pulse output resumes about 25 ms after the last byte; here the 25 ms gap is timed from the conversion step instead.
// - Initial pulses cover origin to position at about 1250 rpm rate.
// - Serial data is revolution count relative to the setup base.
// - Serial is 9600 bps, start, 7-bit ASCII, even parity, stop.
module aprd_readout #(
   parameter int unsigned SETTLE_CYC = aprd_pkg::REQ_SETTLE_CYC,
   parameter int unsigned GAP_CYC = aprd_pkg::TAIL_GAP_CYC,
   parameter int unsigned BAUD_CYC = aprd_pkg::BIT_CYC
) (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // Pins and straps
   input wire logic input_terminal_four,
   input wire logic input_terminal_eight,
   input wire logic servo_on_input,
   input wire logic [1:0] encoder_mode_strap,
   input wire logic res_23bit_strap,
   // Shaft motion from the encoder interface, same clock
   input wire logic shaft_step,
   input wire logic shaft_step_fwd,
   // Encoder emulation and drive outputs
   output logic phase_a_out,
   output logic phase_b_out,
   output logic index_pulse_out,
   output logic motor_enable,
   output logic panel_off_ind
);
   aprd_pkg::aprd_state_t state;
   aprd_pkg::aprd_state_t next_state;
   aprd_pkg::aprd_mode_t mode;
   aprd_pkg::aprd_aphase_t aph;
   logic [3:0] assign_digit;
   logic axis_b;
   logic res23;
   logic strap_taken;
   logic [2:0] sync_req;
   logic [2:0] sync_son;
   logic req_level;
   logic son_level;
   logic req_prev;
   logic [15:0] turns;
   logic [22:0] shaft_pos;
   logic [31:0] timer;
   logic [31:0] gap_timer;
   logic [31:0] baud_cnt;
   logic [4:0] pulse_tick;
   logic [19:0] bcd;
   logic [15:0] mag;
   logic [4:0] dabble;
   logic neg;
   logic [16:0] pulses_left;
   logic [1:0] quad;
   logic [2:0] byte_idx;
   logic [3:0] bit_idx;
   logic [9:0] frame;
   logic [19:0] bcd_adj;
   logic [6:0] char_now;
   logic [2:0] char_sel;
   logic req_pin;
   logic req_rise;
   logic busy;
   logic bit_end;
   logic pulse_en;
   logic gap_done;
   logic [22:0] pos_top;
   logic ahb_wr;
   logic [31:0] rd_mux;

   // Pick the request terminal, then filter it through three stages
   // terminal routing
   assign req_pin = (assign_digit == aprd_pkg::ASSIGN_TERMINAL) &&
                    (axis_b ? input_terminal_eight : input_terminal_four);
   always_ff @(posedge hclk or negedge hresetn)
      if (!hresetn)
      begin
         sync_req <= 3'h0;
         sync_son <= 3'h0;
         req_level <= 1'b0;
         son_level <= 1'b0;
      end
      else
      begin
         sync_req <= {sync_req[1:0], req_pin};
         sync_son <= {sync_son[1:0], servo_on_input};
         // accept a change once stages agree
         if (sync_req[1] == sync_req[2])
            req_level <= sync_req[2];
         if (sync_son[1] == sync_son[2])
            son_level <= sync_son[2];
      end

   // low level is no request; incremental mode ignores it
   assign req_rise = req_level && !req_prev && (mode != aprd_pkg::APRD_MODE_INCR);
   assign busy = (state != aprd_pkg::APRD_NORMAL);
   // hold motor off and show off during transfer
   assign motor_enable = son_level && !busy;
   assign panel_off_ind = busy;
   assign pos_top = res23 ? aprd_pkg::TOP_23BIT : aprd_pkg::TOP_17BIT;
   // origin pulse always on the index line
   assign index_pulse_out = (shaft_pos == 23'h000000);

   // usage mode and resolution caught once after reset release
   always_ff @(posedge hclk or negedge hresetn)
      if (!hresetn)
      begin
         strap_taken <= 1'b0;
         mode <= aprd_pkg::APRD_MODE_INCR;
         res23 <= 1'b0;
         req_prev <= 1'b0;
      end
      else
      begin
         req_prev <= req_level;
         if (!strap_taken)
         begin
            strap_taken <= 1'b1;
            mode <= aprd_pkg::aprd_mode_t'(encoder_mode_strap == 2'b11 ?
                    2'b01 : encoder_mode_strap);
            res23 <= res_23bit_strap;
         end
      end

   // Shaft position and revolution tracking
   always_ff @(posedge hclk or negedge hresetn)
      if (!hresetn)
      begin
         shaft_pos <= 23'h000000;
         turns <= 16'h0000;
      end
      else if (ahb_wr && aph.addr == aprd_pkg::OFS_CTRL && hwdata[aprd_pkg::CTRL_CLR_TURNS_BIT])
         turns <= 16'h0000;
      else if (shaft_step && shaft_step_fwd)
      begin
         shaft_pos <= (shaft_pos == pos_top) ? 23'h000000 : shaft_pos + 23'h000001;
         if (shaft_pos == pos_top)
            turns <= turns + 16'h0001;
      end
      else if (shaft_step)
      begin
         shaft_pos <= (shaft_pos == 23'h000000) ? pos_top : shaft_pos - 23'h000001;
         if (shaft_pos == 23'h000000)
            turns <= turns - 16'h0001;
      end

   // Bit and pulse rate enables
   assign bit_end = (baud_cnt == BAUD_CYC - 1);
   assign pulse_en = (pulse_tick == 5'(aprd_pkg::PULSE_CYC - 1));
   assign gap_done = (gap_timer == 32'h00000000);

   // Transfer sequencer
   always_comb
   begin
      next_state = state;
      unique case (state)
         aprd_pkg::APRD_NORMAL:
            if (req_rise)
               next_state = aprd_pkg::APRD_SETTLE;
         aprd_pkg::APRD_SETTLE:
            if (timer == SETTLE_CYC - 1)
               next_state = aprd_pkg::APRD_CONVERT;
         aprd_pkg::APRD_CONVERT:
            // silent absolute mode skips the serial data
            if (dabble == aprd_pkg::DABBLE_STEPS)
               next_state = (mode == aprd_pkg::APRD_MODE_ABS_SERIAL) ?
                            aprd_pkg::APRD_SEND : aprd_pkg::APRD_PULSES;
         aprd_pkg::APRD_SEND:
            if (bit_end && bit_idx == aprd_pkg::LAST_BIT && byte_idx == aprd_pkg::LAST_BYTE)
               next_state = aprd_pkg::APRD_PULSES;
         aprd_pkg::APRD_PULSES:
            // normal output once pulses done and gap elapsed
            if (pulses_left == 17'h00000 && gap_done)
               next_state = aprd_pkg::APRD_NORMAL;
         default:
            next_state = aprd_pkg::APRD_NORMAL;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn)
      if (!hresetn)
         state <= aprd_pkg::APRD_NORMAL;
      else
         state <= next_state;

   // Settle timer and binary to decimal conversion of the turn count
   assign bcd_adj = {bcd[19:16] > 4'h4 ? bcd[19:16] + 4'h3 : bcd[19:16],
                     bcd[15:12] > 4'h4 ? bcd[15:12] + 4'h3 : bcd[15:12],
                     bcd[11:8] > 4'h4 ? bcd[11:8] + 4'h3 : bcd[11:8],
                     bcd[7:4] > 4'h4 ? bcd[7:4] + 4'h3 : bcd[7:4],
                     bcd[3:0] > 4'h4 ? bcd[3:0] + 4'h3 : bcd[3:0]};
   always_ff @(posedge hclk or negedge hresetn)
      if (!hresetn)
      begin
         timer <= 32'h00000000;
         bcd <= 20'h00000;
         mag <= 16'h0000;
         neg <= 1'b0;
         dabble <= 5'h00;
         pulses_left <= 17'h00000;
      end
      else if (state == aprd_pkg::APRD_SETTLE)
      begin
         timer <= timer + 32'h00000001;
         dabble <= 5'h00;
         bcd <= 20'h00000;
         neg <= turns[15];
         mag <= turns[15] ? 16'h0000 - turns : turns;
         pulses_left <= res23 ? shaft_pos[22:aprd_pkg::RES_SHIFT] : shaft_pos[16:0];
      end
      else if (state == aprd_pkg::APRD_CONVERT && dabble != aprd_pkg::DABBLE_STEPS)
      begin
         bcd <= {bcd_adj[18:0], mag[15]};
         mag <= {mag[14:0], 1'b0};
         dabble <= dabble + 5'h01;
      end
      else
      begin
         timer <= 32'h00000000;
         if (state == aprd_pkg::APRD_PULSES && pulse_en && pulses_left != 17'h00000)
            pulses_left <= pulses_left - 17'h00001;
      end

   // Slot to load: first one at rest, the following one at each reload
   assign char_sel = (state == aprd_pkg::APRD_SEND) ? byte_idx + 3'h1 : 3'h0;
   // Character of each byte slot
   always_comb
   begin
      unique case (char_sel)
         3'h0: char_now = aprd_pkg::CHAR_HEAD;
         3'h1: char_now = neg ? aprd_pkg::CHAR_MINUS : aprd_pkg::CHAR_PLUS;
         3'h2: char_now = aprd_pkg::CHAR_ZERO + {3'h0, bcd[19:16]};
         3'h3: char_now = aprd_pkg::CHAR_ZERO + {3'h0, bcd[15:12]};
         3'h4: char_now = aprd_pkg::CHAR_ZERO + {3'h0, bcd[11:8]};
         3'h5: char_now = aprd_pkg::CHAR_ZERO + {3'h0, bcd[7:4]};
         3'h6: char_now = aprd_pkg::CHAR_ZERO + {3'h0, bcd[3:0]};
         3'h7: char_now = aprd_pkg::CHAR_END;
      endcase
   end

   // Serial transmitter, line idles high
   always_ff @(posedge hclk or negedge hresetn)
      if (!hresetn)
      begin
         baud_cnt <= 32'h00000000;
         bit_idx <= 4'h0;
         byte_idx <= 3'h0;
         frame <= 10'h3ff;
      end
      else if (state != aprd_pkg::APRD_SEND)
      begin
         baud_cnt <= 32'h00000000;
         bit_idx <= 4'h0;
         byte_idx <= 3'h0;
         // stop, even parity, 7 data LSB first, start
         frame <= {1'b1, ^char_now, char_now, 1'b0};
      end
      else if (bit_end)
      begin
         baud_cnt <= 32'h00000000;
         if (bit_idx == aprd_pkg::LAST_BIT)
         begin
            bit_idx <= 4'h0;
            byte_idx <= byte_idx + 3'h1;
            frame <= {1'b1, ^char_now, char_now, 1'b0};
         end
         else
         begin
            bit_idx <= bit_idx + 4'h1;
            frame <= {1'b1, frame[9:1]};
         end
      end
      else
         baud_cnt <= baud_cnt + 32'h00000001;

   // Pulse rate divider and tail gap timer
   always_ff @(posedge hclk or negedge hresetn)
      if (!hresetn)
      begin
         pulse_tick <= 5'h00;
         gap_timer <= 32'h00000000;
      end
      else
      begin
         pulse_tick <= pulse_en ? 5'h00 : pulse_tick + 5'h01;
         // 25 ms counted from the conversion step, before the first byte
         if (state == aprd_pkg::APRD_CONVERT)
            gap_timer <= GAP_CYC;
         else if (!gap_done)
            gap_timer <= gap_timer - 32'h00000001;
      end

   // Quadrature generator and phase outputs
   always_ff @(posedge hclk or negedge hresetn)
      if (!hresetn)
      begin
         quad <= 2'b11; // A high, B low: no false edge after reset
         phase_a_out <= 1'b1;
         phase_b_out <= 1'b0;
      end
      else
      begin
         // initial pulses forward, then normal pulses follow the shaft
         if (state == aprd_pkg::APRD_PULSES && pulse_en && pulses_left != 17'h00000)
            quad <= quad + 2'b01;
         else if (state == aprd_pkg::APRD_NORMAL && shaft_step)
            quad <= shaft_step_fwd ? quad + 2'b01 : quad - 2'b01;
         // phase A carries serial data while sending
         if (state == aprd_pkg::APRD_SEND)
            phase_a_out <= frame[0];
         else if (state == aprd_pkg::APRD_SETTLE || state == aprd_pkg::APRD_CONVERT)
            phase_a_out <= 1'b1;
         else
            phase_a_out <= quad[1];
         phase_b_out <= quad[1] ^ quad[0];
      end

   // AHB-Lite address phase capture and register writes
   assign ahb_wr = aph.valid && aph.write;
   always_ff @(posedge hclk or negedge hresetn)
      if (!hresetn)
      begin
         aph <= '0;
         assign_digit <= aprd_pkg::ASSIGN_RST;
         axis_b <= 1'b0;
      end
      else
      begin
         if (hready)
            aph <= '{valid: hsel && htrans[1], write: hwrite, addr: haddr[7:0]};
         if (ahb_wr && aph.addr == aprd_pkg::OFS_CTRL)
         begin
            assign_digit <= hwdata[aprd_pkg::CTRL_ASSIGN_LSB +: 4];
            axis_b <= hwdata[aprd_pkg::CTRL_AXIS_B_BIT];
         end
      end

   // Read data select; unmapped offsets read zero
   assign rd_mux =
      (aph.addr == aprd_pkg::OFS_CTRL) ? {23'h0, 4'h0, axis_b, assign_digit} :
      (aph.addr == aprd_pkg::OFS_STATUS) ? {24'h0, req_level, res23, mode, busy, state} :
      (aph.addr == aprd_pkg::OFS_TURNS) ? {{16{turns[15]}}, turns} :
      (aph.addr == aprd_pkg::OFS_POSITION) ? {9'h000, shaft_pos} : 32'h00000000;
   assign hrdata = (aph.valid && !aph.write) ? rd_mux : 32'h00000000;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
endmodule : aprd_readout
`default_nettype wire

//--- verif/aprd_sva.sv
`timescale 1ns/1ps
`default_nettype none
// Pin level checks of the readout block
module aprd_sva #(
   parameter int unsigned SETTLE_CYC = 20,
   parameter int unsigned GAP_CYC = 50,
   parameter int unsigned BAUD_CYC = 8
) (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // Request pins and shaft motion
   input wire logic input_terminal_four,
   input wire logic input_terminal_eight,
   input wire logic shaft_step,
   input wire logic shaft_step_fwd,
   // Drive outputs
   input wire logic phase_a_out,
   input wire logic phase_b_out,
   input wire logic index_pulse_out,
   input wire logic motor_enable,
   input wire logic panel_off_ind
);
   localparam int unsigned LAST_RISE = SETTLE_CYC + 17 + 79 * BAUD_CYC;
   int unsigned busy_cnt;
   int unsigned low_cnt;
   default clocking @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   // Cycles into a transfer and length of each low run on phase A
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         busy_cnt <= 0;
         low_cnt <= 0;
      end
      else
      begin
         busy_cnt <= panel_off_ind ? busy_cnt + 1 : 0;
         low_cnt <= phase_a_out ? 0 : low_cnt + 1;
      end
   end
   // Phase A fall at any point of a transfer, and bit end during the serial span
   sequence s_frame_start;
      panel_off_ind && $fell(phase_a_out);
   endsequence
   sequence s_bit_end;
      panel_off_ind && busy_cnt >= SETTLE_CYC && busy_cnt < LAST_RISE && $rose(phase_a_out);
   endsequence
   property p_motor_off;
      panel_off_ind |-> !motor_enable;
   endproperty
   a_motor_off: assert property (p_motor_off) else $error("motor on in transfer");
   property p_req_cause;
      $rose(panel_off_ind) |-> $past(input_terminal_four, 3) || $past(input_terminal_eight, 3);
   endproperty
   a_req_cause: assert property (p_req_cause) else $error("transfer without request");
   property p_settle_idle;
      panel_off_ind && busy_cnt >= 2 && busy_cnt < SETTLE_CYC |-> phase_a_out;
   endproperty
   a_settle_idle: assert property (p_settle_idle) else $error("phase A busy in settle");
   property p_start_late;
      s_frame_start |-> busy_cnt >= SETTLE_CYC;
   endproperty
   a_start_late: assert property (p_start_late) else $error("frame too early");
   property p_bit_len;
      s_bit_end |-> low_cnt % BAUD_CYC == 0;
   endproperty
   a_bit_len: assert property (p_bit_len) else $error("bit length wrong");
   property p_index;
      index_pulse_out && shaft_step && shaft_step_fwd |=> !index_pulse_out;
   endproperty
   a_index: assert property (p_index) else $error("index stuck at origin");
   property p_quad_one;
      !panel_off_ind && $past(!panel_off_ind) |-> !($changed(phase_a_out) && $changed(phase_b_out));
   endproperty
   a_quad_one: assert property (p_quad_one) else $error("both phases moved");
   property p_quad_follow;
      !panel_off_ind && shaft_step |-> ##[1:3] ($changed(phase_a_out) || $changed(phase_b_out));
   endproperty
   a_quad_follow: assert property (p_quad_follow) else $error("step not output");
endmodule : aprd_sva
bind aprd_readout aprd_sva #(
   .SETTLE_CYC(SETTLE_CYC),
   .GAP_CYC(GAP_CYC),
   .BAUD_CYC(BAUD_CYC)
) u_sva (
   .hclk(hclk),
   .hresetn(hresetn),
   .input_terminal_four(input_terminal_four),
   .input_terminal_eight(input_terminal_eight),
   .shaft_step(shaft_step),
   .shaft_step_fwd(shaft_step_fwd),
   .phase_a_out(phase_a_out),
   .phase_b_out(phase_b_out),
   .index_pulse_out(index_pulse_out),
   .motor_enable(motor_enable),
   .panel_off_ind(panel_off_ind)
);
`default_nettype wire

//--- verif/aprd_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// Upper controller: takes serial frames, counts phase B edges
module aprd_host_model #(
   parameter int unsigned BAUD_CYC = 8
) (
   // Clock and clear from the bench
   input wire logic hclk,
   input wire logic clr,
   // Encoder emulation from the drive
   input wire logic phase_a_out,
   input wire logic phase_b_out,
   input wire logic panel_off_ind,
   // Received results
   output logic [7:0][6:0] rx_char,
   output int n_rx,
   output int n_bad,
   output int n_edge
);
   logic [8:0] bits;
   logic last_b;
   // start, seven data bits, even parity, stop
   always
   begin
      @(negedge phase_a_out or posedge clr);
      if (clr)
      begin
         n_rx = 0;
         n_bad = 0;
      end
      else if (panel_off_ind && n_rx < 8)
      begin
         repeat (BAUD_CYC / 2) @(posedge hclk);
         for (int i = 0; i < 9; i++)
         begin
            repeat (BAUD_CYC) @(posedge hclk);
            bits[i] = phase_a_out;
         end
         if ((^bits[7:0]) || !bits[8])
            n_bad++;
         rx_char[n_rx] = bits[6:0];
         n_rx++;
      end
   end
   // phase B edge count cleared before a transfer
   always @(posedge hclk)
   begin
      if (clr)
         n_edge <= 0;
      else if (phase_b_out !== last_b)
         n_edge <= n_edge + 1;
      last_b <= phase_b_out;
   end
endmodule : aprd_host_model
`default_nettype wire

//--- verif/tb.sv
`timescale 1ns/1ps
`default_nettype none
// Bench for the absolute position readout
module tb;
   localparam int unsigned SETTLE = 20;
   localparam int unsigned GAP = 50;
   localparam int unsigned BAUD = 8;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = '0;
   logic [1:0] htrans = 2'b00;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = '0;
   logic req_a = 1'b0;
   logic req_b = 1'b0;
   logic servo = 1'b0;
   logic [1:0] mode = 2'b00;
   logic res23 = 1'b0;
   logic step = 1'b0;
   logic fwd = 1'b1;
   logic clr = 1'b0;
   logic hready, hreadyout, hresp, pa, pb, idx, mot, pan;
   logic [31:0] hrdata, rd_q;
   logic [7:0][6:0] rx_char;
   int n_rx, n_bad, n_edge;
   int n_mismatch = 0;
   int n_checks = 0;
   int cyc = 0;
   assign hready = hreadyout;
   // Design and far side controller
   aprd_readout #(.SETTLE_CYC(SETTLE), .GAP_CYC(GAP), .BAUD_CYC(BAUD)) DUT (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hready),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .input_terminal_four(req_a), .input_terminal_eight(req_b), .servo_on_input(servo),
      .encoder_mode_strap(mode), .res_23bit_strap(res23), .shaft_step(step),
      .shaft_step_fwd(fwd), .phase_a_out(pa), .phase_b_out(pb), .index_pulse_out(idx),
      .motor_enable(mot), .panel_off_ind(pan));
   aprd_host_model #(.BAUD_CYC(BAUD)) u_host (
      .hclk(hclk), .clr(clr), .phase_a_out(pa), .phase_b_out(pb), .panel_off_ind(pan),
      .rx_char(rx_char), .n_rx(n_rx), .n_bad(n_bad), .n_edge(n_edge));
   // Clock
   always #12.5 hclk = ~hclk;
   // Read data sample and run ceiling
   always @(posedge hclk)
   begin
      rd_q <= hrdata;
      cyc <= cyc + 1;
      if (cyc == 40000)
      begin
         n_mismatch++;
         final_report();
      end
   end
   task automatic final_report();
      $display("Checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : final_report
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd,
      output logic [31:0] rd);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'b10;
      do @(posedge hclk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      do @(posedge hclk); while (hready !== 1'b1);
      #1 rd = rd_q;
   endtask : bus
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      logic [31:0] d;
      bus(1'b1, {24'h0, a}, v, d);
   endtask : wr
   task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      logic [31:0] d;
      bus(1'b0, {24'h0, a}, 32'h0, d);
      chk(d & m, e);
   endtask : rchk
   task automatic do_reset(input logic [1:0] m, input logic r);
      @(posedge hclk);
      hresetn <= 1'b0;
      req_a <= 1'b0;
      req_b <= 1'b0;
      mode <= m;
      res23 <= r;
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (4) @(posedge hclk);
   endtask : do_reset
   task automatic steps(input int n, input logic f);
      repeat (n)
      begin
         @(posedge hclk);
         step <= 1'b1;
         fwd <= f;
         @(posedge hclk);
         step <= 1'b0;
         repeat (3) @(posedge hclk);
      end
   endtask : steps
   task automatic wait_pan(input logic v);
      while (pan !== v)
         @(negedge hclk);
   endtask : wait_pan
   task automatic raise(input logic b);
      @(posedge hclk);
      clr <= 1'b1;
      @(posedge hclk);
      clr <= 1'b0;
      req_a <= !b;
      req_b <= b;
   endtask : raise
   function automatic logic [6:0] exp_char(input int t, input int i);
      int m;
      m = (t < 0) ? -t : t;
      if (i == 0)
         return aprd_pkg::CHAR_HEAD;
      if (i == 1)
         return (t < 0) ? aprd_pkg::CHAR_MINUS : aprd_pkg::CHAR_PLUS;
      if (i == 7)
         return aprd_pkg::CHAR_END;
      repeat (6 - i) m = m / 10;
      return aprd_pkg::CHAR_ZERO + 7'(m % 10);
   endfunction : exp_char
   function automatic int enc_val(input int t, input int p0, input logic rev);
      return (rev ? -t : t) * int'(aprd_pkg::INIT_CNT_PER_REV) + p0;
   endfunction : enc_val
   task automatic frame(input int t);
      chk(32'(n_rx), 32'h8);
      chk(32'(n_bad), 32'h0);
      for (int i = 0; i < 8; i++)
         chk({25'h0, rx_char[i]}, {25'h0, exp_char(t, i)});
   endtask : frame
   // idle levels, default map, unmapped place
   task automatic t_reset();
      @(negedge hclk);
      chk({25'h0, hreadyout, hresp, pa, pb, idx, mot, pan}, 32'h54);
      rchk(aprd_pkg::OFS_STATUS, 32'hff, 32'h0);
      wr(8'h10, 32'hffffffff);
      rchk(8'h10, 32'hffffffff, 32'h0);
      rchk(aprd_pkg::OFS_CTRL, 32'h1f, 32'h0);
   endtask : t_reset
   // unrouted request pins are not seen
   task automatic t_unrouted();
      @(posedge hclk);
      servo <= 1'b1;
      req_a <= 1'b1;
      req_b <= 1'b1;
      repeat (40) @(negedge hclk);
      chk({30'h0, pan, mot}, 32'h1);
      @(posedge hclk);
      req_a <= 1'b0;
      req_b <= 1'b0;
   endtask : t_unrouted
   task automatic t_transfer();
      int c;
      wr(aprd_pkg::OFS_CTRL, 32'h4);
      rchk(aprd_pkg::OFS_CTRL, 32'h1f, 32'h4);
      steps(4, 1'b1);
      rchk(aprd_pkg::OFS_POSITION, 32'h7fffff, 32'h4);
      chk({31'h0, idx}, 32'h0);
      raise(1'b0);
      wait_pan(1'b1);
      chk({31'h0, mot}, 32'h0);
      rchk(aprd_pkg::OFS_STATUS, 32'h8, 32'h8);
      @(posedge hclk);
      req_a <= 1'b0;
      repeat (6) @(posedge hclk);
      req_a <= 1'b1;
      c = 0;
      while (pan !== 1'b0)
      begin
         @(negedge hclk);
         c++;
      end
      chk({31'h0, c >= SETTLE + 80 * BAUD}, 32'h1);
      frame(0);
      repeat (2) @(negedge hclk);
      chk(32'(n_edge), 32'h2);
      chk(32'(enc_val(0, 2 * n_edge, 1'b0)), 32'h4);
      chk({31'h0, mot}, 32'h1);
      rchk(aprd_pkg::OFS_STATUS, 32'hf, 32'h0);
   endtask : t_transfer
   task automatic t_axis_b();
      wr(aprd_pkg::OFS_CTRL, 32'h14);
      steps(5, 1'b0);
      rchk(aprd_pkg::OFS_TURNS, 32'hffffffff, 32'hffffffff);
      rchk(aprd_pkg::OFS_POSITION, 32'h7fffff, 32'h1ffff);
      @(posedge hclk);
      req_a <= 1'b0;
      repeat (8) @(posedge hclk);
      req_a <= 1'b1;
      repeat (40) @(negedge hclk);
      chk({31'h0, pan}, 32'h0);
      raise(1'b1);
      wait_pan(1'b1);
      while (n_rx < 8)
         @(negedge hclk);
      frame(-1);
      chk(32'(enc_val(-1, 32'h1ffff, 1'b0)), 32'hffffffff);
      chk(32'(enc_val(-1, 32'h1ffff, 1'b1)), 32'h3ffff);
   endtask : t_axis_b
   // incremental mode, strap change without power cycle
   task automatic t_incr();
      do_reset(2'b01, 1'b0);
      rchk(aprd_pkg::OFS_STATUS, 32'h38, 32'h10);
      wr(aprd_pkg::OFS_CTRL, 32'h4);
      @(posedge hclk);
      mode <= 2'b00;
      req_a <= 1'b1;
      repeat (40) @(negedge hclk);
      chk({31'h0, pan}, 32'h0);
      rchk(aprd_pkg::OFS_STATUS, 32'h30, 32'h10);
   endtask : t_incr
   task automatic t_quiet();
      do_reset(2'b10, 1'b1);
      rchk(aprd_pkg::OFS_STATUS, 32'h70, 32'h60);
      wr(aprd_pkg::OFS_CTRL, 32'h4);
      raise(1'b0);
      wait_pan(1'b1);
      wait_pan(1'b0);
      chk(32'(n_rx), 32'h0);
      chk(32'(n_edge), 32'h0);
   endtask : t_quiet
   // Main sequence
   initial
   begin
      do_reset(2'b00, 1'b0);
      t_reset();
      t_unrouted();
      t_transfer();
      t_axis_b();
      t_incr();
      t_quiet();
      final_report();
   end
endmodule : tb
`default_nettype wire
